// ---- core/tos_pkg.sv ----
// Purpose: Shared constants and types for the timing output selector
// Assumes: Register indices are word indices; byte address is index times four
// Notes:   Codes 10 to 13 carry the user-programmed timing signals
package tos_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Sizes
   localparam int          TOS_OUT_COUNT  = 3;
   localparam int          TOS_SRC_COUNT  = 14;
   localparam int          TOS_ADDR_W     = 12;
   localparam int          TOS_DATA_W     = 32;
   localparam int          TOS_REG_W      = 16;
   localparam int          TOS_CODE_W     = 4;

   ////////////////////////////////////////////////////////////////////////////
   // Register indices as printed, and their byte addresses
   localparam logic [7:0]  TOS_IDX_OUT6   = 8'h48;
   localparam logic [7:0]  TOS_IDX_OUT7   = 8'h49;
   localparam logic [7:0]  TOS_IDX_OUT8   = 8'h4A;
   localparam logic [TOS_ADDR_W-1:0] TOS_ADDR_OUT6 = {2'h0, TOS_IDX_OUT6, 2'h0};
   localparam logic [TOS_ADDR_W-1:0] TOS_ADDR_OUT7 = {2'h0, TOS_IDX_OUT7, 2'h0};
   localparam logic [TOS_ADDR_W-1:0] TOS_ADDR_OUT8 = {2'h0, TOS_IDX_OUT8, 2'h0};

   ////////////////////////////////////////////////////////////////////////////
   // Field layout
   localparam int          TOS_CODE_LSB   = 0;
   localparam int          TOS_DRIVE_BIT  = 4;
   localparam int          TOS_RSVD_LSB   = 5;

   ////////////////////////////////////////////////////////////////////////////
   // Selection codes
   localparam logic [3:0]  TOS_CODE_VSYNC      = 4'h3;
   localparam logic [3:0]  TOS_CODE_VBLANK     = 4'h4;
   localparam logic [3:0]  TOS_CODE_FSYNC      = 4'h5;
   localparam logic [3:0]  TOS_CODE_FDIGITAL   = 4'h6;
   localparam logic [3:0]  TOS_CODE_TEN_FIELD  = 4'h7;
   localparam logic [3:0]  TOS_CODE_DISP_EN    = 4'h8;

   ////////////////////////////////////////////////////////////////////////////
   // Values after reset
   localparam logic [3:0]  TOS_RST_CODE6  = TOS_CODE_FDIGITAL;
   localparam logic [3:0]  TOS_RST_CODE7  = TOS_CODE_TEN_FIELD;
   localparam logic [3:0]  TOS_RST_CODE8  = TOS_CODE_DISP_EN;
   localparam logic        TOS_RST_DRIVE  = 1'b0;

   ////////////////////////////////////////////////////////////////////////////
   // Bus responses
   localparam logic [1:0]  TOS_RESP_OKAY  = 2'h0;
   localparam logic [1:0]  TOS_RESP_SLVERR = 2'h2;

   ////////////////////////////////////////////////////////////////////////////
   // One selector register
   typedef struct packed
   {
      logic             drive_high;
      logic [3:0]       code;
   } tos_sel_type;

endpackage : tos_pkg

// ---- core/tos_out_slice.sv ----
// Purpose: One timing output: source multiplexer and drive strength flop
// Assumes: Timing sources are synchronous to aclk
// Notes:   Output lags the source by one clock
`timescale 1ns/1ps
module tos_out_slice
#(
   parameter int SRC_COUNT = tos_pkg::TOS_SRC_COUNT
)
(
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   input  wire tos_pkg::tos_sel_type  sel,
   input  wire logic [SRC_COUNT-1:0]  timing_src,
   output      logic                  timing_out,
   output      logic                  drive_high
);
   import tos_pkg::*;

   logic next_out;

   ////////////////////////////////////////////////////////////////////////////
   // Unused codes give a quiet low pin rather than an unknown level
   always_comb
   begin
      next_out = 1'b0;
      if (int'(sel.code) < SRC_COUNT)
         next_out = timing_src[sel.code];                   // [RULE1] [RULE5]
   end

   // Registered pin, so the pad never sees mux glitches
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         timing_out <= 1'b0;
      else
         timing_out <= next_out;
   end

   // Drive strength follows its register bit
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         drive_high <= TOS_RST_DRIVE;                       // [RULE7]
      else
         drive_high <= sel.drive_high;                      // [RULE7]
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   property p_route;
      @(posedge aclk) disable iff (!aresetn)
      (int'(sel.code) < SRC_COUNT) |=> (timing_out == $past(timing_src[sel.code]));
   endproperty
   a_route: assert property (p_route)                       // [RULE1]
      else $error("timing output does not follow selected source");

   property p_vblank;
      @(posedge aclk) disable iff (!aresetn)
      (sel.code == TOS_CODE_VBLANK) |=> (timing_out == $past(timing_src[4]));
   endproperty
   a_vblank: assert property (p_vblank)                     // [RULE5]
      else $error("code four does not route vertical blanking");

   property p_drive;
      @(posedge aclk) disable iff (!aresetn)
      $changed(sel.drive_high) |=> (drive_high == $past(sel.drive_high));
   endproperty
   a_drive: assert property (p_drive)                       // [RULE7]
      else $error("drive strength does not follow register bit");

endmodule : tos_out_slice

// ---- core/tos_selector.sv ----
// Contract
// RULE1: Low four bits pick one of fourteen sources
// RULE2: Sixth output resets to field digital code
// RULE3: Seventh output resets to ten-field code
// RULE4: Eighth output resets to display enable code
// RULE5: Code four routes vertical blanking
// RULE6: Software writes zeros to reserved bits
// RULE7: Bit four picks drive strength, resets low
// RULE8: Code and drive bit read and write
// RULE9: Reserved bits always read as zero
//
// Purpose: AXI4-Lite register bank steering three timing output pins
// Assumes: Single clock, synchronous active-low reset
// Notes:   Write and read each take one transaction at a time
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module tos_selector
#(
   parameter int SRC_COUNT = tos_pkg::TOS_SRC_COUNT
)
(
   input  wire logic                              aclk,
   input  wire logic                              aresetn,
   input  wire logic [tos_pkg::TOS_ADDR_W-1:0]    s_axi_awaddr,
   input  wire logic [2:0]                        s_axi_awprot,
   input  wire logic                              s_axi_awvalid,
   output      logic                              s_axi_awready,
   input  wire logic [tos_pkg::TOS_DATA_W-1:0]    s_axi_wdata,
   input  wire logic [3:0]                        s_axi_wstrb,
   input  wire logic                              s_axi_wvalid,
   output      logic                              s_axi_wready,
   output      logic [1:0]                        s_axi_bresp,
   output      logic                              s_axi_bvalid,
   input  wire logic                              s_axi_bready,
   input  wire logic [tos_pkg::TOS_ADDR_W-1:0]    s_axi_araddr,
   input  wire logic [2:0]                        s_axi_arprot,
   input  wire logic                              s_axi_arvalid,
   output      logic                              s_axi_arready,
   output      logic [tos_pkg::TOS_DATA_W-1:0]    s_axi_rdata,
   output      logic [1:0]                        s_axi_rresp,
   output      logic                              s_axi_rvalid,
   input  wire logic                              s_axi_rready,
   input  wire logic [SRC_COUNT-1:0]              timing_src,
   output      logic [tos_pkg::TOS_OUT_COUNT-1:0] timing_out,
   output      logic [tos_pkg::TOS_OUT_COUNT-1:0] drive_high
);
   import tos_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   localparam logic [TOS_ADDR_W-1:0] ADDR_TABLE [TOS_OUT_COUNT] =
      '{TOS_ADDR_OUT6, TOS_ADDR_OUT7, TOS_ADDR_OUT8};
   localparam logic [3:0] RST_TABLE [TOS_OUT_COUNT] =
      '{TOS_RST_CODE6, TOS_RST_CODE7, TOS_RST_CODE8};

   tos_sel_type                sel_reg [TOS_OUT_COUNT];
   logic [TOS_ADDR_W-1:0]      aw_addr;
   logic [TOS_DATA_W-1:0]      w_data;
   logic [3:0]                 w_strb;
   logic                       aw_held;
   logic                       w_held;
   logic                       do_write;
   logic [TOS_OUT_COUNT-1:0]   wr_hit;
   logic [TOS_OUT_COUNT-1:0]   rd_hit;
   logic [TOS_DATA_W-1:0]      next_rdata;
   logic                       aw_take;
   logic                       w_take;
   logic                       ar_take;

   ////////////////////////////////////////////////////////////////////////////
   // Handshake terms; prot carries no meaning for this bank
   assign aw_take  = s_axi_awvalid && s_axi_awready;
   assign w_take   = s_axi_wvalid && s_axi_wready;
   assign ar_take  = s_axi_arvalid && s_axi_arready;
   assign do_write = aw_held && w_held && !s_axi_bvalid;

   // Address decode against the byte addresses of the bank
   always_comb
   begin
      for (int i = 0; i < TOS_OUT_COUNT; i++)
      begin
         wr_hit[i] = (aw_addr == ADDR_TABLE[i]);
         rd_hit[i] = (s_axi_araddr == ADDR_TABLE[i]);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Write address channel: held until the write completes
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held       <= 1'b0;
         aw_addr       <= '0;
         s_axi_awready <= 1'b1;
      end
      else if (aw_take)
      begin
         aw_held       <= 1'b1;
         aw_addr       <= s_axi_awaddr;
         s_axi_awready <= 1'b0;
      end
      else if (do_write)
         aw_held       <= 1'b0;
      else if (s_axi_bvalid && s_axi_bready)
         s_axi_awready <= 1'b1;
   end

   // Write data channel, taken in either order against the address
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_held       <= 1'b0;
         w_data       <= '0;
         w_strb       <= '0;
         s_axi_wready <= 1'b1;
      end
      else if (w_take)
      begin
         w_held       <= 1'b1;
         w_data       <= s_axi_wdata;
         w_strb       <= s_axi_wstrb;
         s_axi_wready <= 1'b0;
      end
      else if (do_write)
         w_held       <= 1'b0;
      else if (s_axi_bvalid && s_axi_bready)
         s_axi_wready <= 1'b1;
   end

   // Response one cycle after both halves are held
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= TOS_RESP_OKAY;
      end
      else if (do_write)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (|wr_hit) ? TOS_RESP_OKAY : TOS_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Selector registers; only byte lane 0 holds live bits, so a write
   // without strobe 0 leaves the register as it was. Reserved bits
   // are dropped on the way in, which keeps them zero whatever
   // software sends.
   for (genvar g = 0; g < TOS_OUT_COUNT; g++)
   begin : g_reg
      always_ff @(posedge aclk)
      begin
         if (!aresetn)
         begin
            sel_reg[g].drive_high <= TOS_RST_DRIVE;               // [RULE7]
            sel_reg[g].code       <= RST_TABLE[g];                // [RULE2] [RULE3] [RULE4]
         end
         else if (do_write && wr_hit[g] && w_strb[0])
         begin
            sel_reg[g].drive_high <= w_data[TOS_DRIVE_BIT];       // [RULE8]
            sel_reg[g].code       <= w_data[TOS_CODE_LSB +: TOS_CODE_W]; // [RULE8]
         end
      end

      tos_out_slice
      #(
         .SRC_COUNT (SRC_COUNT)
      )
      u_slice
      (
         .aclk       (aclk),
         .aresetn    (aresetn),
         .sel        (sel_reg[g]),
         .timing_src (timing_src),
         .timing_out (timing_out[g]),
         .drive_high (drive_high[g])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data: live fields in the low bits, everything else zero
   always_comb
   begin
      next_rdata = '0;
      for (int i = 0; i < TOS_OUT_COUNT; i++)
      begin
         if (rd_hit[i])
         begin
            next_rdata[TOS_DRIVE_BIT]                = sel_reg[i].drive_high; // [RULE8]
            next_rdata[TOS_CODE_LSB +: TOS_CODE_W]   = sel_reg[i].code;       // [RULE8]
         end
      end
   end

   // Read channel answers one cycle after the address is taken
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= TOS_RESP_OKAY;
      end
      else if (ar_take)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= next_rdata;                            // [RULE9]
         s_axi_rresp   <= (|rd_hit) ? TOS_RESP_OKAY : TOS_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   property p_reset6;
      @(posedge aclk)
      !aresetn |=> (sel_reg[0].code == TOS_CODE_FDIGITAL);
   endproperty
   a_reset6: assert property (p_reset6)                      // [RULE2]
      else $error("sixth selector reset code wrong");

   property p_reset7;
      @(posedge aclk)
      !aresetn |=> (sel_reg[1].code == TOS_CODE_TEN_FIELD);
   endproperty
   a_reset7: assert property (p_reset7)                      // [RULE3]
      else $error("seventh selector reset code wrong");

   property p_reset8;
      @(posedge aclk)
      !aresetn |=> (sel_reg[2].code == TOS_CODE_DISP_EN);
   endproperty
   a_reset8: assert property (p_reset8)                      // [RULE4]
      else $error("eighth selector reset code wrong");

   property p_drive_reset;
      @(posedge aclk)
      !aresetn |=> ##1 (drive_high == '0);
   endproperty
   a_drive_reset: assert property (p_drive_reset)            // [RULE7]
      else $error("drive strength not low after reset");

   property p_reserved_zero;
      @(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid |-> (s_axi_rdata[TOS_DATA_W-1:TOS_RSVD_LSB] == '0);
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)        // [RULE9]
      else $error("reserved read bits not zero");

   property p_write_lands;
      @(posedge aclk) disable iff (!aresetn)
      (do_write && wr_hit[0] && w_strb[0]) |=>
         (sel_reg[0].code == $past(w_data[3:0]))
         && (sel_reg[0].drive_high == $past(w_data[4]));
   endproperty
   a_write_lands: assert property (p_write_lands)            // [RULE8]
      else $error("write to sixth selector not stored");

   property p_read_back;
      @(posedge aclk) disable iff (!aresetn)
      (ar_take && rd_hit[1]) |=>
         s_axi_rvalid && (s_axi_rdata[4:0] == $past({sel_reg[1].drive_high,
                                                     sel_reg[1].code}));
   endproperty
   a_read_back: assert property (p_read_back)                // [RULE8]
      else $error("read of seventh selector wrong");

   property p_pin_follows;
      @(posedge aclk) disable iff (!aresetn)
      (sel_reg[2].code == TOS_CODE_DISP_EN) ##1
      (sel_reg[2].code == TOS_CODE_DISP_EN) |->
         (timing_out[2] == $past(timing_src[TOS_CODE_DISP_EN]));
   endproperty
   a_pin_follows: assert property (p_pin_follows)            // [RULE1]
      else $error("eighth pin does not follow display enable");

   property p_bresp_timing;
      @(posedge aclk) disable iff (!aresetn)
      do_write |=> s_axi_bvalid;
   endproperty
   a_bresp_timing: assert property (p_bresp_timing)          // [RULE8]
      else $error("write response not raised after write");

endmodule : tos_selector

// ---- tb/tos_selector_bench.sv ----
// Purpose: Self-checking bench for the timing output selector register bank
// Assumes: AXI4-Lite master tasks; answers awaited, never counted
// Notes:   Pins checked with one-hot and inverted patterns on the sources
`timescale 1ns/1ps
module tos_selector_bench;
   import tos_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Signals
   logic                      aclk;
   logic                      aresetn;
   logic [TOS_ADDR_W-1:0]     s_axi_awaddr;
   logic                      s_axi_awvalid;
   logic                      s_axi_awready;
   logic [TOS_DATA_W-1:0]     s_axi_wdata;
   logic [3:0]                s_axi_wstrb;
   logic                      s_axi_wvalid;
   logic                      s_axi_wready;
   logic [1:0]                s_axi_bresp;
   logic                      s_axi_bvalid;
   logic                      s_axi_bready;
   logic [TOS_ADDR_W-1:0]     s_axi_araddr;
   logic                      s_axi_arvalid;
   logic                      s_axi_arready;
   logic [TOS_DATA_W-1:0]     s_axi_rdata;
   logic [1:0]                s_axi_rresp;
   logic                      s_axi_rvalid;
   logic                      s_axi_rready;
   logic [TOS_SRC_COUNT-1:0]  timing_src;
   logic [TOS_OUT_COUNT-1:0]  timing_out;
   logic [TOS_OUT_COUNT-1:0]  drive_high;
   int                        miscompares;
   int                        n_checks;
   logic [TOS_ADDR_W-1:0]     addr_t [3];
   logic [3:0]                rst_t  [3];
   logic [31:0]               rd_val;
   logic [1:0]                resp;

   tos_selector #(.SRC_COUNT(TOS_SRC_COUNT)) dut_u
   (
      .aclk          (aclk),
      .aresetn       (aresetn),
      .s_axi_awaddr  (s_axi_awaddr),
      .s_axi_awprot  (3'h0),
      .s_axi_awvalid (s_axi_awvalid),
      .s_axi_awready (s_axi_awready),
      .s_axi_wdata   (s_axi_wdata),
      .s_axi_wstrb   (s_axi_wstrb),
      .s_axi_wvalid  (s_axi_wvalid),
      .s_axi_wready  (s_axi_wready),
      .s_axi_bresp   (s_axi_bresp),
      .s_axi_bvalid  (s_axi_bvalid),
      .s_axi_bready  (s_axi_bready),
      .s_axi_araddr  (s_axi_araddr),
      .s_axi_arprot  (3'h0),
      .s_axi_arvalid (s_axi_arvalid),
      .s_axi_arready (s_axi_arready),
      .s_axi_rdata   (s_axi_rdata),
      .s_axi_rresp   (s_axi_rresp),
      .s_axi_rvalid  (s_axi_rvalid),
      .s_axi_rready  (s_axi_rready),
      .timing_src    (timing_src),
      .timing_out    (timing_out),
      .drive_high    (drive_high)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Clock, 100 MHz
   always #5 aclk = ~aclk;

   ////////////////////////////////////////////////////////////////////////////
   // Compare tasks and verdict
   task chk_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
      n_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED at %0t: %s got %h want %h", $time, msg, got, exp);
      end
   endtask : chk_word

   task chk_pin(input logic got, input logic exp, input string msg);
      n_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask : chk_pin

   task tally_and_finish();
      if (miscompares == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : tally_and_finish

   ////////////////////////////////////////////////////////////////////////////
   // Bus master; starts one edge late so no strobe is assigned twice per step
   task wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
           output logic [1:0] r);
      logic aw_ok;
      logic w_ok;
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_wstrb   <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      aw_ok = 1'b0;
      w_ok  = 1'b0;
      while (!(aw_ok && w_ok))
      begin
         @(posedge aclk);
         if (!aw_ok && s_axi_awready === 1'b1)
         begin
            aw_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_ok && s_axi_wready === 1'b1)
         begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      while (s_axi_bvalid !== 1'b1)
         @(posedge aclk);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr

   task rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do
         @(posedge aclk);
      while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1)
         @(posedge aclk);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd

   // Source pattern and its inverse, so a wrong selection cannot match twice
   task check_pin(input int idx, input logic [3:0] c);
      logic [13:0] pat;
      logic        exp;
      for (int k = 0; k < 2; k++)
      begin
         pat = (k == 0) ? (14'h0001 << c) : ~(14'h0001 << c);
         exp = (c < 4'hE) ? pat[c] : 1'b0;
         @(posedge aclk);
         timing_src <= pat;
         repeat (2) @(posedge aclk);
         #1;
         chk_pin(timing_out[idx], exp, "timing output level");
      end
   endtask : check_pin

   ////////////////////////////////////////////////////////////////////////////
   // Watchdog; the tests need roughly 710 cycles
   initial
   begin
      #200us;
      miscompares++;
      tally_and_finish();
   end

   ////////////////////////////////////////////////////////////////////////////
   // Test sequence
   initial
   begin
      aclk = 1'b0;
      aresetn = 1'b0;
      s_axi_awaddr = '0;
      s_axi_awvalid = 1'b0;
      s_axi_wdata = '0;
      s_axi_wstrb = 4'h0;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_araddr = '0;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      timing_src = '0;
      miscompares = 0;
      n_checks = 0;
      addr_t = '{TOS_ADDR_OUT6, TOS_ADDR_OUT7, TOS_ADDR_OUT8};
      rst_t = '{TOS_RST_CODE6, TOS_RST_CODE7, TOS_RST_CODE8};
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      // Values after reset, on the bus and on the pins
      for (int i = 0; i < 3; i++)
      begin
         rd(addr_t[i], rd_val, resp);
         chk_word(rd_val, {28'h0, rst_t[i]}, "reset value");
         chk_word({30'h0, resp}, {30'h0, TOS_RESP_OKAY}, "read response");
         check_pin(i, rst_t[i]);
      end
      chk_word({29'h0, drive_high}, 32'h0, "drive after reset");
      // Every code on every output, drive bit toggled with code parity
      for (int i = 0; i < 3; i++)
      begin
         for (int c = 0; c < 16; c++)
         begin
            wr(addr_t[i], {27'h0, c[0], c[3:0]}, 4'hF, resp);
            rd(addr_t[i], rd_val, resp);
            chk_word(rd_val, {27'h0, c[0], c[3:0]}, "read back");
            check_pin(i, c[3:0]);
            chk_pin(drive_high[i], c[0], "drive strength");
         end
      end
      // Code four on the eighth output
      wr(TOS_ADDR_OUT8, {28'h0, TOS_CODE_VBLANK}, 4'hF, resp);
      check_pin(2, TOS_CODE_VBLANK);
      // Ones in reserved bits are dropped
      wr(TOS_ADDR_OUT7, 32'hFFFF_FFE9, 4'hF, resp);
      rd(TOS_ADDR_OUT7, rd_val, resp);
      chk_word(rd_val, 32'h0000_0009, "reserved bits");
      // Low byte strobe off leaves the register as it was
      wr(TOS_ADDR_OUT6, 32'h0000_0013, 4'hE, resp);
      chk_word({30'h0, resp}, {30'h0, TOS_RESP_OKAY}, "masked write response");
      rd(TOS_ADDR_OUT6, rd_val, resp);
      chk_word(rd_val, 32'h0000_001F, "masked write");
      // Unmapped place: refused both ways, eighth register untouched
      wr(12'h12C, 32'h0000_0003, 4'hF, resp);
      chk_word({30'h0, resp}, {30'h0, TOS_RESP_SLVERR}, "unmapped write");
      rd(12'h12C, rd_val, resp);
      chk_word({30'h0, resp}, {30'h0, TOS_RESP_SLVERR}, "unmapped read");
      chk_word(rd_val, 32'h0, "unmapped data");
      rd(TOS_ADDR_OUT8, rd_val, resp);
      chk_word(rd_val, {28'h0, TOS_CODE_VBLANK}, "eighth kept");
      // Reset in mid-run must undo earlier writes, drive bit included
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd(TOS_ADDR_OUT6, rd_val, resp);
      chk_word(rd_val, {28'h0, TOS_RST_CODE6}, "reset after writes");
      chk_pin(drive_high[0], TOS_RST_DRIVE, "drive after second reset");
      tally_and_finish();
   end

endmodule : tos_selector_bench
